// file: rtl/tw8_pkg.sv
// Package of constants and carrier types for the 8-bit timer waveform output unit
`default_nettype none

package tw8_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] TW8_OFF_CTRL_A    = 3'h0;
  localparam logic [2:0] TW8_OFF_CTRL_B    = 3'h1;
  localparam logic [2:0] TW8_OFF_COUNTER   = 3'h2;
  localparam logic [2:0] TW8_OFF_COMPARE_A = 3'h3;
  localparam logic [2:0] TW8_OFF_COMPARE_B = 3'h4;
  localparam logic [2:0] TW8_OFF_FLAGS     = 3'h5;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TW8_POS_MODE_A    = 6;
  localparam int TW8_POS_MODE_B    = 4;
  localparam int TW8_POS_WGM_LO    = 0;
  localparam int TW8_POS_FORCE_A   = 7;
  localparam int TW8_POS_FORCE_B   = 6;
  localparam int TW8_POS_WGM_TOP   = 3;
  localparam int TW8_POS_FLAG_CMPB = 2;
  localparam int TW8_POS_FLAG_CMPA = 1;
  localparam int TW8_POS_FLAG_OVF  = 0;

  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  localparam logic [7:0] TW8_BOTTOM    = 8'h00;
  localparam logic [7:0] TW8_MAX       = 8'hFF;
  localparam logic [7:0] TW8_RST_BYTE  = 8'h00;
  localparam logic [7:0] TW8_READ_ZERO = 8'h00;
  localparam logic [1:0] TW8_RST_OC    = 2'b00;
  localparam logic [2:0] TW8_RST_WGM   = 3'h0;

  // Waveform mode field values
  localparam logic [2:0] TW8_WGM_NORMAL   = 3'h0;
  localparam logic [2:0] TW8_WGM_CTC      = 3'h2;
  localparam logic [2:0] TW8_WGM_FAST_MAX = 3'h3;
  localparam logic [2:0] TW8_WGM_FAST_OCR = 3'h7;

  // Output mode field values
  localparam logic [1:0] TW8_COM_OFF    = 2'h0;
  localparam logic [1:0] TW8_COM_TOGGLE = 2'h1;
  localparam logic [1:0] TW8_COM_CLEAR  = 2'h2;
  localparam logic [1:0] TW8_COM_SET    = 2'h3;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cmp_b;
    logic cmp_a;
    logic ovf;
  } tw8_flags_t;

  typedef struct packed {
    logic [1:0] value;
    logic [1:0] dir;
  } tw8_port_t;

  typedef struct packed {
    logic [1:0] out;
    logic [1:0] oe_n;
  } tw8_pin_t;

endpackage

`default_nettype wire

// file: rtl/tw8_timer.sv
// 8-bit timer counter with compare output state, waveform modes and pin override
`default_nettype none

// Contract
// - Reset clears both internal output state bits to zero.
// - Nonzero output mode replaces the port value with the output state.
// - Output state reaches the pin only when direction bit selects output.
// - Pin override depends only on output mode, not on waveform mode.
// - Output mode zero leaves the output state untouched on matches.
// - New output mode acts at next match; force strobe acts now in non-PWM.
// - Counting depends only on waveform mode; output mode only shapes output.
// - Normal mode counts up always and wraps from 0xFF to 0x00.
// - Normal mode sets overflow when counter becomes zero; counting never clears it.
// - Clear-on-compare mode clears counter on match with compare register A.
// - Compare A unbuffered there; written below count, counter wraps before matching.
// - Clear-on-compare mode sets channel A flag each time counter hits top.
// - Clear-on-compare with channel A mode one toggles output on every match.
// - Clear-on-compare sets overflow when counter passes from maximum to zero.
// - Modes three and seven are fast PWM; top is 0xFF or compare A.
// - Fast PWM mode two clears on match, sets at bottom; mode three inverse.
// - Fast PWM clears counter the tick after top; bottom action then.
// - Fast PWM sets overflow each time counter turns over from top to bottom.
// - Fast PWM mode one toggles channel A only with top mode bit; not B.
// - Compare at bottom gives spike per MAX+1 ticks; at max gives constant.
// - Fast PWM keeps compare registers double buffered, also in toggle mode.
// - PWM writes go to buffer loaded at top; other modes write directly.
// - Match sets compare flag on next tick; cleared by ack or writing one.
// - Force strobe updates output like a match, no flag, no counter change.
module tw8_timer
  import tw8_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata,
  // Timer clock enable
  input wire logic timer_tick,
  // Interrupt acknowledges
  input wire logic ack_ovf,
  input wire logic ack_cmp_a,
  input wire logic ack_cmp_b,
  // Port register side
  input wire tw8_port_t port_in,
  // Pin side and flags
  output tw8_pin_t pin,
  output tw8_flags_t flags
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [1:0] mode_ff [2];
  logic [1:0] nxt_mode [2];
  logic [2:0] wgm_ff;
  logic [2:0] nxt_wgm;
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  logic [7:0] ocr_cpu_ff [2];
  logic [7:0] nxt_ocr_cpu [2];
  logic [7:0] ocr_act_ff [2];
  logic [7:0] nxt_ocr_act [2];
  logic [1:0] oc_ff;
  logic [1:0] nxt_oc;
  logic blk_ff;
  logic nxt_blk;
  tw8_flags_t flags_ff;
  tw8_flags_t nxt_flags;
  tw8_pin_t pin_ff;
  tw8_pin_t nxt_pin;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic is_pwm;
  logic is_ctc;
  logic [7:0] top_val;
  logic at_top;
  logic [1:0] match;
  logic [1:0] force_strobe;
  logic wr_ctrl_a;
  logic wr_ctrl_b;
  logic wr_cnt;
  logic wr_flags;

  always_comb begin
    is_pwm = (wgm_ff == TW8_WGM_FAST_MAX) || (wgm_ff == TW8_WGM_FAST_OCR);
    is_ctc = (wgm_ff == TW8_WGM_CTC);
    top_val = (wgm_ff == TW8_WGM_FAST_OCR) ? ocr_act_ff[0] : TW8_MAX;
    at_top = is_pwm && (cnt_ff == top_val);
    // A counter write blocks matches for the following tick
    match[0] = (cnt_ff == ocr_act_ff[0]) && !blk_ff;
    match[1] = (cnt_ff == ocr_act_ff[1]) && !blk_ff;
    wr_ctrl_a = reg_we && (reg_addr == TW8_OFF_CTRL_A);
    wr_ctrl_b = reg_we && (reg_addr == TW8_OFF_CTRL_B);
    wr_cnt = reg_we && (reg_addr == TW8_OFF_COUNTER);
    wr_flags = reg_we && (reg_addr == TW8_OFF_FLAGS);
    force_strobe[0] = wr_ctrl_b && reg_wdata[TW8_POS_FORCE_A] && !is_pwm;
    force_strobe[1] = wr_ctrl_b && reg_wdata[TW8_POS_FORCE_B] && !is_pwm;
  end

  // ----------------------------------------------------------------
  // Output state action per channel
  // ----------------------------------------------------------------
  function automatic logic oc_action(
    input logic [1:0] mode,
    input logic oc,
    input logic hit,
    input logic bottom,
    input logic pwm,
    input logic toggle_ok,
    input logic hit_is_top
  );
    logic res;
    res = oc;
    if (pwm) begin
      case (mode)
        TW8_COM_TOGGLE: begin
          if (hit && toggle_ok) res = !oc;
        end
        TW8_COM_CLEAR: begin
          if (bottom) res = 1'b1;
          else if (hit && !hit_is_top) res = 1'b0;
        end
        TW8_COM_SET: begin
          if (bottom) res = 1'b0;
          else if (hit && !hit_is_top) res = 1'b1;
        end
        default: res = oc;
      endcase
    end else if (hit) begin
      case (mode)
        TW8_COM_TOGGLE: res = !oc;
        TW8_COM_CLEAR: res = 1'b0;
        TW8_COM_SET: res = 1'b1;
        default: res = oc;
      endcase
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_mode = mode_ff;
    nxt_wgm = wgm_ff;
    nxt_cnt = cnt_ff;
    nxt_ocr_cpu = ocr_cpu_ff;
    nxt_ocr_act = ocr_act_ff;
    nxt_oc = oc_ff;
    nxt_blk = blk_ff;
    nxt_flags = flags_ff;
    nxt_pin = pin_ff;
    nxt_rdata = TW8_READ_ZERO;

    // Control writes: output mode only affects later actions
    if (wr_ctrl_a) begin
      nxt_mode[0] = reg_wdata[TW8_POS_MODE_A +: 2];
      nxt_mode[1] = reg_wdata[TW8_POS_MODE_B +: 2];
      nxt_wgm[1:0] = reg_wdata[TW8_POS_WGM_LO +: 2];
    end
    if (wr_ctrl_b) begin
      nxt_wgm[2] = reg_wdata[TW8_POS_WGM_TOP];
    end

    // Counter sequence from waveform mode only
    if (timer_tick) begin
      nxt_blk = 1'b0;
      if (is_pwm) begin
        nxt_cnt = at_top ? TW8_BOTTOM : 8'(cnt_ff + 8'h01);
      end else if (is_ctc && match[0]) begin
        nxt_cnt = TW8_BOTTOM;
      end else begin
        nxt_cnt = 8'(cnt_ff + 8'h01);
      end
      if (is_pwm ? at_top : (cnt_ff == TW8_MAX)) begin
        nxt_flags.ovf = 1'b1;
      end
      if (match[0]) nxt_flags.cmp_a = 1'b1;
      if (match[1]) nxt_flags.cmp_b = 1'b1;
      // Buffered compare values load as the count turns over at top
      if (at_top) begin
        nxt_ocr_act = ocr_cpu_ff;
      end
      nxt_oc[0] = oc_action(mode_ff[0], oc_ff[0], match[0], at_top, is_pwm,
                            wgm_ff[2], ocr_act_ff[0] == top_val);
      nxt_oc[1] = oc_action(mode_ff[1], oc_ff[1], match[1], at_top, is_pwm,
                            1'b0, ocr_act_ff[1] == top_val);
    end

    // Force strobes act as a match on the output only
    if (force_strobe[0]) begin
      nxt_oc[0] = oc_action(mode_ff[0], oc_ff[0], 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    end
    if (force_strobe[1]) begin
      nxt_oc[1] = oc_action(mode_ff[1], oc_ff[1], 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    end

    // CPU counter write overrides counting and blocks the next match
    if (wr_cnt) begin
      nxt_cnt = reg_wdata;
      nxt_blk = 1'b1;
    end

    // Compare writes: buffered in PWM, direct otherwise
    if (reg_we && (reg_addr == TW8_OFF_COMPARE_A)) begin
      nxt_ocr_cpu[0] = reg_wdata;
      if (!is_pwm) nxt_ocr_act[0] = reg_wdata;
    end
    if (reg_we && (reg_addr == TW8_OFF_COMPARE_B)) begin
      nxt_ocr_cpu[1] = reg_wdata;
      if (!is_pwm) nxt_ocr_act[1] = reg_wdata;
    end

    // Flag clear by ack or write one; a set in the same cycle wins
    if ((wr_flags && reg_wdata[TW8_POS_FLAG_OVF]) || ack_ovf) begin
      nxt_flags.ovf = timer_tick && (is_pwm ? at_top : (cnt_ff == TW8_MAX));
    end
    if ((wr_flags && reg_wdata[TW8_POS_FLAG_CMPA]) || ack_cmp_a) begin
      nxt_flags.cmp_a = timer_tick && match[0];
    end
    if ((wr_flags && reg_wdata[TW8_POS_FLAG_CMPB]) || ack_cmp_b) begin
      nxt_flags.cmp_b = timer_tick && match[1];
    end

    // Pin override per channel
    for (int i = 0; i < 2; i++) begin
      nxt_pin.out[i] = (mode_ff[i] != TW8_COM_OFF) ? oc_ff[i] : port_in.value[i];
      nxt_pin.oe_n[i] = !port_in.dir[i];
    end

    // Read data, one cycle after the strobe
    if (reg_re) begin
      case (reg_addr)
        TW8_OFF_CTRL_A: begin
          nxt_rdata = {mode_ff[0], mode_ff[1], 2'b00, wgm_ff[1:0]};
        end
        TW8_OFF_CTRL_B: begin
          nxt_rdata = {4'h0, wgm_ff[2], 3'h0};
        end
        TW8_OFF_COUNTER: nxt_rdata = cnt_ff;
        TW8_OFF_COMPARE_A: nxt_rdata = ocr_cpu_ff[0];
        TW8_OFF_COMPARE_B: nxt_rdata = ocr_cpu_ff[1];
        TW8_OFF_FLAGS: nxt_rdata = {5'h00, flags_ff};
        default: nxt_rdata = TW8_READ_ZERO;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_ff[0] <= TW8_COM_OFF;
      mode_ff[1] <= TW8_COM_OFF;
      wgm_ff <= TW8_RST_WGM;
      cnt_ff <= TW8_RST_BYTE;
      ocr_cpu_ff[0] <= TW8_RST_BYTE;
      ocr_cpu_ff[1] <= TW8_RST_BYTE;
      ocr_act_ff[0] <= TW8_RST_BYTE;
      ocr_act_ff[1] <= TW8_RST_BYTE;
      oc_ff <= TW8_RST_OC;
      blk_ff <= 1'b0;
      flags_ff <= '0;
      pin_ff.out <= 2'b00;
      pin_ff.oe_n <= 2'b11;
      rdata_ff <= TW8_READ_ZERO;
    end else begin
      mode_ff <= nxt_mode;
      wgm_ff <= nxt_wgm;
      cnt_ff <= nxt_cnt;
      ocr_cpu_ff <= nxt_ocr_cpu;
      ocr_act_ff <= nxt_ocr_act;
      oc_ff <= nxt_oc;
      blk_ff <= nxt_blk;
      flags_ff <= nxt_flags;
      pin_ff <= nxt_pin;
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;
  assign pin = pin_ff;
  assign flags = flags_ff;

endmodule // tw8_timer

`default_nettype wire

// file: verif/tw8_timer_assertions.sv
// Port-level assertions for the timer waveform output unit
`default_nettype none

module tw8_timer_chk
  import tw8_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  input wire logic [7:0] reg_rdata,
  // Timer and acknowledges
  input wire logic timer_tick,
  input wire logic ack_ovf,
  input wire logic ack_cmp_a,
  input wire logic ack_cmp_b,
  // Port and pins
  input wire tw8_port_t port_in,
  input wire tw8_pin_t pin,
  input wire tw8_flags_t flags
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_RST_CLEAR: assert property ($fell(rst) |-> flags == 3'b000 && pin.oe_n == 2'b11)
    else $error("state not cleared by reset");
  AST_OE_DIR: assert property (!$past(rst) |-> pin.oe_n == ~$past(port_in.dir))
    else $error("pin enable does not follow direction");
  AST_RD_IDLE: assert property (!reg_re |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  AST_RD_UNMAPPED: assert property (reg_re && reg_addr > TW8_OFF_FLAGS |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_RD_FLAGS: assert property (reg_re && reg_addr == TW8_OFF_FLAGS |=> reg_rdata[2:0] == $past(flags))
    else $error("flag read mismatch");
  AST_OVF_HOLD: assert property (flags.ovf && !ack_ovf && !(reg_we && reg_addr == TW8_OFF_FLAGS && reg_wdata[0])
    |=> flags.ovf)
    else $error("overflow flag lost");
  AST_OVF_TICK: assert property (!timer_tick |=> !$rose(flags.ovf))
    else $error("overflow set without tick");
  AST_CMPA_TICK: assert property (!timer_tick |=> !$rose(flags.cmp_a))
    else $error("compare flag set without tick");
  AST_ACK_OVF: assert property (ack_ovf && !timer_tick |=> !flags.ovf)
    else $error("overflow not cleared by ack");
  AST_ACK_CMPA: assert property (ack_cmp_a && !timer_tick |=> !flags.cmp_a)
    else $error("compare flag not cleared by ack");
  AST_W1C_CMPB: assert property (reg_we && reg_addr == TW8_OFF_FLAGS && reg_wdata[2] && !timer_tick
    |=> !flags.cmp_b)
    else $error("compare flag not cleared by write");
endmodule // tw8_timer_chk

bind tw8_timer tw8_timer_chk i_chk (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .timer_tick(timer_tick), .ack_ovf(ack_ovf),
  .ack_cmp_a(ack_cmp_a), .ack_cmp_b(ack_cmp_b), .port_in(port_in), .pin(pin), .flags(flags));

`default_nettype wire

// file: verif/tw8_port_model.sv
// Port pin partner: port register bits and resolved pad level
`default_nettype none

module tw8_port_model
  import tw8_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Bench commands
  input wire logic [1:0] val_set,
  input wire logic [1:0] dir_set,
  // Timer side
  input wire tw8_pin_t pin,
  output tw8_port_t port_in,
  output logic [1:0] pad
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] last_ff = 2'b00;
  assign port_in = '{value: val_set, dir: dir_set};
  // Released pad floats: show the inverse of the last driven level
  assign pad = (pin.out & ~pin.oe_n) | (~last_ff & pin.oe_n);
  always_ff @(posedge sys_clk) last_ff <= (pad & ~pin.oe_n) | (last_ff & pin.oe_n);
endmodule // tw8_port_model

`default_nettype wire

// file: verif/tw8_timer_tb.sv
// Self-checking bench for the timer waveform output unit
`default_nettype none

module tw8_timer_tb
  import tw8_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [7:0] reg_rdata;
  logic timer_tick = 1'b0;
  logic ack_ovf = 1'b0;
  logic ack_cmp_a = 1'b0;
  logic ack_cmp_b = 1'b0;
  logic [1:0] val_set = 2'b10;
  logic [1:0] dir_set = 2'b01;
  logic [1:0] pad;
  tw8_port_t port_in;
  tw8_pin_t pin;
  tw8_flags_t flags;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;

  tw8_timer i_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata), .timer_tick(timer_tick), .ack_ovf(ack_ovf), .ack_cmp_a(ack_cmp_a),
    .ack_cmp_b(ack_cmp_b), .port_in(port_in), .pin(pin), .flags(flags));
  tw8_port_model i_port (.sys_clk(sys_clk), .val_set(val_set), .dir_set(dir_set), .pin(pin), .port_in(port_in),
    .pad(pad));

  initial forever #5 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    if (mismatches == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_we <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input string nm);
    @(posedge sys_clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_re <= 1'b0;
    #1 chk(nm, e, reg_rdata);
  endtask
  task automatic tick(input int n);
    @(posedge sys_clk);
    timer_tick <= 1'b1;
    repeat (n) @(posedge sys_clk);
    timer_tick <= 1'b0;
    #1;
  endtask
  task automatic pin_chk(input logic e);
    @(posedge sys_clk);
    #1 chk("pin_a", {7'h0, e}, {7'h0, pin.out[0]});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_normal();
    rd(3'h6, 8'h00, "unmapped");
    wr(TW8_OFF_COUNTER, 8'hFF);
    tick(1);
    chk("flags", 8'h01, {5'h0, flags});
    tick(2);
    rd(TW8_OFF_COUNTER, 8'h02, "count");
    chk("flags", 8'h07, {5'h0, flags});
    @(posedge sys_clk);
    ack_ovf <= 1'b1;
    ack_cmp_a <= 1'b1;
    @(posedge sys_clk);
    ack_ovf <= 1'b0;
    ack_cmp_a <= 1'b0;
    wr(TW8_OFF_FLAGS, 8'h04);
    #1 chk("flags", 8'h00, {5'h0, flags});
  endtask
  task automatic t_force();
    wr(TW8_OFF_CTRL_A, 8'hC0);
    wr(TW8_OFF_CTRL_B, 8'h80);
    pin_chk(1'b1);
    chk("pins", 8'h0E, {4'h0, pin});
    chk("pad_a", 8'h01, {7'h0, pad[0]});
    chk("flags", 8'h00, {5'h0, flags});
    rd(TW8_OFF_COUNTER, 8'h02, "count");
    @(posedge sys_clk);
    dir_set <= 2'b00;
    repeat (2) @(posedge sys_clk);
    #1 chk("oe_n", 8'h03, {6'h0, pin.oe_n});
    chk("pad_rel", 8'h00, {7'h0, pad[0]});
    @(posedge sys_clk);
    dir_set <= 2'b01;
  endtask
  task automatic t_ctc();
    wr(TW8_OFF_CTRL_A, 8'h42);
    wr(TW8_OFF_COMPARE_A, 8'h03);
    wr(TW8_OFF_COUNTER, 8'h00);
    tick(4);
    chk("flags", 8'h02, {5'h0, flags});
    pin_chk(1'b0);
    rd(TW8_OFF_COUNTER, 8'h00, "count");
    tick(2);
    wr(TW8_OFF_COMPARE_A, 8'h01);
    tick(255);
    rd(TW8_OFF_COUNTER, 8'h01, "count");
    chk("ovf", 8'h01, {7'h0, flags.ovf});
    tick(1);
    rd(TW8_OFF_COUNTER, 8'h00, "count");
  endtask
  task automatic t_fast();
    wr(TW8_OFF_FLAGS, 8'h07);
    wr(TW8_OFF_CTRL_A, 8'h00);
    wr(TW8_OFF_COMPARE_A, 8'h10);
    wr(TW8_OFF_CTRL_A, 8'hC3);
    wr(TW8_OFF_COUNTER, 8'hFF);
    tick(1);
    chk("ovf", 8'h01, {7'h0, flags.ovf});
    pin_chk(1'b0);
    tick(16);
    rd(TW8_OFF_COUNTER, 8'h10, "count");
    pin_chk(1'b0);
    tick(1);
    pin_chk(1'b1);
    chk("cmp_a", 8'h01, {7'h0, flags.cmp_a});
  endtask
  task automatic t_fast7();
    chk("cmp_b", 8'h01, {7'h0, flags.cmp_b});
    @(posedge sys_clk);
    ack_cmp_b <= 1'b1;
    @(posedge sys_clk);
    ack_cmp_b <= 1'b0;
    #1 chk("cmp_b", 8'h00, {7'h0, flags.cmp_b});
    wr(TW8_OFF_CTRL_A, 8'h43);
    wr(TW8_OFF_CTRL_B, 8'h88);
    pin_chk(1'b1);
    wr(TW8_OFF_COMPARE_A, 8'h05);
    rd(TW8_OFF_COMPARE_A, 8'h05, "cmp_a_buf");
    wr(TW8_OFF_COUNTER, 8'h0F);
    wr(TW8_OFF_FLAGS, 8'h07);
    tick(2);
    chk("flags", 8'h03, {5'h0, flags});
    rd(TW8_OFF_COUNTER, 8'h00, "count");
    pin_chk(1'b0);
    tick(6);
    rd(TW8_OFF_COUNTER, 8'h00, "count");
    pin_chk(1'b1);
    wr(TW8_OFF_CTRL_A, 8'h03);
    pin_chk(1'b0);
    tick(6);
    wr(TW8_OFF_CTRL_A, 8'h63);
    pin_chk(1'b1);
    tick(6);
    @(posedge sys_clk);
    #1 chk("pin_b", 8'h01, {7'h0, pin.out[1]});
    tick(1);
    @(posedge sys_clk);
    #1 chk("pin_b", 8'h00, {7'h0, pin.out[1]});
  endtask

  initial begin
    repeat (15) @(posedge sys_clk);
    #1 chk("reset", 8'h03, {1'b0, flags, pin});
    @(posedge sys_clk);
    rst <= 1'b0;
    t_normal();
    t_force();
    t_ctc();
    t_fast();
    t_fast7();
    print_verdict();
  end
endmodule // tw8_timer_tb

`default_nettype wire
